// [core/byte_queue.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module byte_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign full = (count_reg == (AW+1)'(DEPTH));
	assign empty = (count_reg == '0);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	a_queue_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
		full && !pop |=> full) else $error("Queue count changed while full without pop");
endmodule

// [core/printer_port.sv]
// Register-driven standard printer parallel port
//
// Overview of operation
// (RULE1) After reset the data port is an input and its pins are not driven.
// (RULE2) Command bit 5 low enables driving the data register onto the data pins; it resets high.
// (RULE3) Status bit 7 reads the inverted busy input, 0 meaning the printer cannot take data.
// (RULE4) Status bit 6 reads the acknowledge input as is, 0 meaning the byte was taken.
// (RULE5) Status bit 5 reads the paper-out input as is, 1 meaning out of paper.
// (RULE6) Status bit 4 reads the online input as is, 1 meaning the printer is powered.
// (RULE7) Status bit 3 reads the active-low fault input as is, 0 meaning an error.
// (RULE8) Command bit 4 is storage only and raises no interrupt.
// (RULE9) Command bit 3 high selects the printer and drives the select pin low.
// (RULE10) Command bit 2 drives the initialize pin at the same polarity, 0 initializing.
// (RULE11) Command bit 1 high requests auto line feed and drives its pin low.
// (RULE12) Software pulses command bit 0 low-high-low and the strobe pin shows its inverse.
// (RULE13) Data reads return pin levels while not driving and the last written byte while driving.
// (RULE14) Reserved status and command bits read zero and ignore writes.
`timescale 1ns/1ns
module printer_port #(
	parameter int QUEUE_WORDS = printer_port_pkg::QUEUE_DEPTH
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [printer_port_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic WR_READY,
	input wire logic [7:0] PRINTER_DATA_BUS_IN,
	output logic [7:0] PRINTER_DATA_BUS_OUT,
	output logic PRINTER_DATA_BUS_OE,
	input wire logic BUSY_PIN,
	input wire logic ACK_PIN_N,
	input wire logic MEDIA_EXHAUSTED_PIN,
	input wire logic PRINTER_ONLINE_PIN,
	input wire logic FAULT_PIN_N,
	output logic PRINTER_CHOOSE_PIN_N,
	output logic INIT_PIN_N,
	output logic AUTO_LINEFEED_PIN_N,
	output logic DATA_LATCH_PIN_N
);
	localparam int SW = printer_port_pkg::SYNC_W;

	printer_port_pkg::command_s cmd_reg;
	printer_port_pkg::status_pins_s status_now;
	printer_port_pkg::slot_state_e slot_reg;
	printer_port_pkg::slot_state_e slot_next;
	logic [SW-1:0] raw_in;
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;
	logic [SW-1:0] sync3_reg;
	logic [SW-1:0] filt_reg;
	logic [7:0] last_written_reg;
	logic [7:0] data_out_reg;
	logic [7:0] rdata_next;
	logic [7:0] status_byte;
	logic [7:0] command_byte;
	logic [7:0] q_data;
	logic q_valid;
	logic q_ready;
	logic q_in_ready;
	logic wr_data;
	logic wr_cmd;
	logic latch_prev_reg;
	logic latch_rise;
	logic latch_fall;

	assign wr_data = REG_WR && (REG_ADDR == printer_port_pkg::DATA_PORT_OFS);
	assign wr_cmd = REG_WR && (REG_ADDR == printer_port_pkg::COMMAND_PORT_OFS);
	assign WR_READY = q_in_ready;

	// Pin inputs: three stages, accept a level once stages two and three agree
	assign raw_in = {PRINTER_DATA_BUS_IN, BUSY_PIN, ACK_PIN_N, MEDIA_EXHAUSTED_PIN,
		PRINTER_ONLINE_PIN, FAULT_PIN_N};

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			filt_reg <= '0;
		end else begin
			filt_reg <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
		end
	end

	assign status_now = filt_reg[4:0];

	// Command port storage, reserved bits dropped
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			cmd_reg <= printer_port_pkg::command_s'(printer_port_pkg::COMMAND_RESET[5:0]); // [RULE1] [RULE2]
		end else if (wr_cmd) begin
			cmd_reg <= printer_port_pkg::command_s'(REG_WDATA[5:0]); // [RULE14] [RULE8]
		end
	end

	// Control pins follow the command bits
	assign PRINTER_DATA_BUS_OE = !cmd_reg.drive_enable_n; // [RULE2]
	assign PRINTER_DATA_BUS_OUT = data_out_reg; // [RULE2]
	assign PRINTER_CHOOSE_PIN_N = !cmd_reg.printer_choose; // [RULE9]
	assign INIT_PIN_N = cmd_reg.init_n; // [RULE10]
	assign AUTO_LINEFEED_PIN_N = !cmd_reg.auto_linefeed; // [RULE11]
	assign DATA_LATCH_PIN_N = !cmd_reg.data_latch_pulse; // [RULE12]

	// Strobe bit edges pace the byte queue
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			latch_prev_reg <= 1'b0;
		end else begin
			latch_prev_reg <= cmd_reg.data_latch_pulse;
		end
	end

	assign latch_rise = cmd_reg.data_latch_pulse && !latch_prev_reg;
	assign latch_fall = !cmd_reg.data_latch_pulse && latch_prev_reg;

	byte_queue #(
		.WIDTH(8),
		.DEPTH(QUEUE_WORDS)
	) u_queue (
		.clk(CLOCK),
		.rst_n(RST_N),
		.in_data(REG_WDATA),
		.in_valid(wr_data),
		.in_ready(q_in_ready),
		.out_data(q_data),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.full(),
		.empty()
	);

	assign q_ready = (slot_reg == printer_port_pkg::SLOT_FREE);

	always_comb begin
		slot_next = slot_reg;
		unique case (slot_reg)
			printer_port_pkg::SLOT_FREE: begin
				if (q_valid) begin
					slot_next = printer_port_pkg::SLOT_LOADED;
				end
			end
			printer_port_pkg::SLOT_LOADED: begin
				if (latch_rise) begin
					slot_next = printer_port_pkg::SLOT_LATCHING;
				end
			end
			printer_port_pkg::SLOT_LATCHING: begin
				if (latch_fall) begin
					slot_next = printer_port_pkg::SLOT_FREE; // [RULE12]
				end
			end
			default: begin
				slot_next = printer_port_pkg::SLOT_FREE;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			slot_reg <= printer_port_pkg::SLOT_FREE;
		end else begin
			slot_reg <= slot_next;
		end
	end

	// Byte on the pins is taken from the queue when the slot is free
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			data_out_reg <= printer_port_pkg::DATA_RESET;
		end else if (q_valid && q_ready) begin
			data_out_reg <= q_data;
		end
	end

	// Last byte accepted from software
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			last_written_reg <= printer_port_pkg::DATA_RESET;
		end else if (wr_data && q_in_ready) begin
			last_written_reg <= REG_WDATA;
		end
	end

	// Status byte assembly
	always_comb begin
		status_byte = '0; // [RULE14]
		status_byte[printer_port_pkg::ST_BUSY_N_BIT] = !status_now.busy; // [RULE3]
		status_byte[printer_port_pkg::ST_ACK_N_BIT] = status_now.ack_n; // [RULE4]
		status_byte[printer_port_pkg::ST_MEDIA_BIT] = status_now.media_exhausted; // [RULE5]
		status_byte[printer_port_pkg::ST_ONLINE_BIT] = status_now.printer_online; // [RULE6]
		status_byte[printer_port_pkg::ST_FAULT_N_BIT] = status_now.fault_n; // [RULE7]
	end

	assign command_byte = {2'b00, cmd_reg}; // [RULE14]

	// Read mux, registered
	always_comb begin
		rdata_next = '0;
		unique case (REG_ADDR)
			printer_port_pkg::DATA_PORT_OFS: begin
				rdata_next = cmd_reg.drive_enable_n ? filt_reg[12:5] : last_written_reg; // [RULE13]
			end
			printer_port_pkg::STATUS_PORT_OFS: begin
				rdata_next = status_byte;
			end
			printer_port_pkg::COMMAND_PORT_OFS: begin
				rdata_next = command_byte;
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= '0;
		end else if (REG_RD) begin
			REG_RDATA <= rdata_next;
		end
	end

	a_data_undriven_reset: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE1]
		$rose(RST_N) |-> !PRINTER_DATA_BUS_OE)
		else $error("Data pins driven right after reset");

	a_drive_follows_enable: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE2]
		wr_cmd && !REG_WDATA[printer_port_pkg::CMD_DRIVE_EN_N_BIT] |=> PRINTER_DATA_BUS_OE)
		else $error("Data pins not driven after enable written");

	a_busy_inverted: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE3]
		REG_RD && REG_ADDR == printer_port_pkg::STATUS_PORT_OFS
		|=> REG_RDATA[7] == !$past(filt_reg[4]))
		else $error("Busy status not inverted");

	a_ack_direct: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE4]
		REG_RD && REG_ADDR == printer_port_pkg::STATUS_PORT_OFS
		|=> REG_RDATA[6] == $past(filt_reg[3]))
		else $error("Acknowledge status wrong");

	a_media_online_fault: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE5]
		REG_RD && REG_ADDR == printer_port_pkg::STATUS_PORT_OFS
		|=> REG_RDATA[5:3] == $past(filt_reg[2:0]) && REG_RDATA[2:0] == 3'b000)
		else $error("Paper, online or fault status wrong");

	a_pin_polarity: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE9]
		wr_cmd |=> PRINTER_CHOOSE_PIN_N == !$past(REG_WDATA[3])
		&& INIT_PIN_N == $past(REG_WDATA[2])
		&& AUTO_LINEFEED_PIN_N == !$past(REG_WDATA[1]))
		else $error("Control pin polarity wrong");

	a_strobe_pulse: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE12]
		wr_cmd ##1 1'b1 |-> DATA_LATCH_PIN_N == !$past(REG_WDATA[0]))
		else $error("Strobe pin not inverse of command bit");

	a_readback_driving: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE13]
		REG_RD && REG_ADDR == printer_port_pkg::DATA_PORT_OFS && PRINTER_DATA_BUS_OE
		|=> REG_RDATA == $past(last_written_reg))
		else $error("Data readback wrong while driving");

	a_reserved_cmd_zero: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE14]
		REG_RD && REG_ADDR == printer_port_pkg::COMMAND_PORT_OFS |=> REG_RDATA[7:6] == 2'b00)
		else $error("Reserved command bits not zero");

	a_queue_paced: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE12]
		slot_reg != printer_port_pkg::SLOT_FREE |=> $stable(PRINTER_DATA_BUS_OUT))
		else $error("Pin byte changed before strobe completed");

	a_refused_write_kept: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE13]
		wr_data && !q_in_ready |=> last_written_reg == $past(last_written_reg))
		else $error("Refused data write changed the readback byte");

	a_cmd_stored: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE14]
		wr_cmd |=> command_byte == {2'b00, $past(REG_WDATA[5:0])})
		else $error("Command port does not hold the written bits");

	a_readback_pins: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE13]
		REG_RD && REG_ADDR == printer_port_pkg::DATA_PORT_OFS && !PRINTER_DATA_BUS_OE
		|=> REG_RDATA == $past(filt_reg[12:5]))
		else $error("Data readback wrong while not driving");

	a_unmapped_zero: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE14]
		REG_RD && REG_ADDR != printer_port_pkg::DATA_PORT_OFS
		&& REG_ADDR != printer_port_pkg::STATUS_PORT_OFS
		&& REG_ADDR != printer_port_pkg::COMMAND_PORT_OFS |=> REG_RDATA == 8'h00)
		else $error("Unmapped address did not read zero");
endmodule

// [pkg/printer_port_pkg.sv]
// Constants and types shared by the printer port design
package printer_port_pkg;
	localparam int ADDR_W = 5;
	localparam logic [4:0] DATA_PORT_OFS = 5'h18;
	localparam logic [4:0] STATUS_PORT_OFS = 5'h19;
	localparam logic [4:0] COMMAND_PORT_OFS = 5'h1a;
	localparam int ST_BUSY_N_BIT = 7;
	localparam int ST_ACK_N_BIT = 6;
	localparam int ST_MEDIA_BIT = 5;
	localparam int ST_ONLINE_BIT = 4;
	localparam int ST_FAULT_N_BIT = 3;
	localparam int CMD_DRIVE_EN_N_BIT = 5;
	localparam int CMD_IRQ_GATE_BIT = 4;
	localparam int CMD_CHOOSE_BIT = 3;
	localparam int CMD_INIT_N_BIT = 2;
	localparam int CMD_LINEFEED_BIT = 1;
	localparam int CMD_LATCH_BIT = 0;
	localparam logic [7:0] STATUS_USED_MASK = 8'hf8;
	localparam logic [7:0] COMMAND_USED_MASK = 8'h3f;
	localparam logic [7:0] COMMAND_RESET = 8'h24;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int QUEUE_DEPTH = 16;
	localparam int SYNC_W = 13;

	typedef struct packed {
		logic busy;
		logic ack_n;
		logic media_exhausted;
		logic printer_online;
		logic fault_n;
	} status_pins_s;

	typedef struct packed {
		logic drive_enable_n;
		logic port_interrupt_gate;
		logic printer_choose;
		logic init_n;
		logic auto_linefeed;
		logic data_latch_pulse;
	} command_s;

	typedef enum logic [1:0] {
		SLOT_FREE = 2'b00,
		SLOT_LOADED = 2'b01,
		SLOT_LATCHING = 2'b11
	} slot_state_e;
endpackage

// [tb/printer_model.sv]
// Printer model on the far side of the parallel port
`timescale 1ns/1ns
module printer_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic latch_n,
	input wire logic hold_busy,
	input wire logic hold_ack_n,
	input wire logic ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] data_in,
	output logic busy,
	output logic ack_n
);
	logic [7:0] pattern;
	logic [3:0] cnt;
	logic prev_latch;
	logic [7:0] got[$];
	// Released bus shows ext_val while ext_en is high, else a changing pattern
	assign data_in = data_oe ? data_out : (ext_en ? ext_val : pattern);
	assign busy = hold_busy | (cnt > 4'h2);
	assign ack_n = hold_ack_n & ~(cnt == 4'h1 || cnt == 4'h2);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pattern <= 8'h00;
			cnt <= 4'h0;
			prev_latch <= 1'b1;
		end else begin
			pattern <= pattern + 8'h01;
			prev_latch <= latch_n;
			if (prev_latch && !latch_n) begin
				cnt <= 4'h6;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
	// Byte taken on the falling strobe edge
	always @(negedge latch_n) begin
		if (rst_n) begin
			got.push_back(data_out);
		end
	end
endmodule

// [tb/printer_parallel_port_bench.sv]
// Self-checking bench for the printer port
`timescale 1ns/1ns
module printer_parallel_port_bench;
	logic CLOCK = 1'b0;
	logic RST_N = 1'b0;
	logic [4:0] REG_ADDR = 5'h00;
	logic [7:0] REG_WDATA = 8'h00;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [7:0] REG_RDATA, DIN, DOUT, EXT_VAL = 8'h00;
	logic WR_READY, OE, BUSY, ACK_N, CH_N, INIT_N, LF_N, LATCH_N;
	logic MEDIA = 1'b0, ONLINE = 1'b0, FAULT_N = 1'b1;
	logic HOLD_BUSY = 1'b0, HOLD_ACK_N = 1'b1, EXT_EN = 1'b0;
	int errors = 0, checked = 0, n;
	integer seed = 32'ha313_5de6;
	logic [7:0] v, d, exp_q[$];
	always #25 CLOCK = ~CLOCK;
	printer_port u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.WR_READY(WR_READY), .PRINTER_DATA_BUS_IN(DIN), .PRINTER_DATA_BUS_OUT(DOUT),
		.PRINTER_DATA_BUS_OE(OE), .BUSY_PIN(BUSY), .ACK_PIN_N(ACK_N),
		.MEDIA_EXHAUSTED_PIN(MEDIA), .PRINTER_ONLINE_PIN(ONLINE), .FAULT_PIN_N(FAULT_N),
		.PRINTER_CHOOSE_PIN_N(CH_N), .INIT_PIN_N(INIT_N), .AUTO_LINEFEED_PIN_N(LF_N),
		.DATA_LATCH_PIN_N(LATCH_N));
	printer_model u_pr (.clk(CLOCK), .rst_n(RST_N), .data_out(DOUT), .data_oe(OE),
		.latch_n(LATCH_N), .hold_busy(HOLD_BUSY), .hold_ack_n(HOLD_ACK_N),
		.ext_en(EXT_EN), .ext_val(EXT_VAL), .data_in(DIN), .busy(BUSY), .ack_n(ACK_N));
	function automatic logic [7:0] stat_exp();
		return {~HOLD_BUSY, HOLD_ACK_N, MEDIA, ONLINE, FAULT_N, 3'b000};
	endfunction
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] w);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= w;
		REG_WR <= 1'b1;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] r);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		@(negedge CLOCK);
		r = REG_RDATA;
	endtask
	task automatic strobe();
		repeat (3) @(posedge CLOCK);
		wr(5'h1a, 8'h05);
		wr(5'h1a, 8'h04);
		repeat (8) @(posedge CLOCK);
	endtask
	task automatic end_sim();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge CLOCK);
		errors++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge CLOCK);
		RST_N <= 1'b1;
		@(negedge CLOCK);
		chk("oe_reset", 8'(OE), 8'h00);
		rd(5'h1a, d);
		chk("cmd_reset", d, 8'h24);
		for (int i = 0; i < 10; i++) begin
			v = 8'($random(seed));
			wr(5'h1a, v);
			@(negedge CLOCK);
			chk("pins", 8'({OE, CH_N, INIT_N, LF_N, LATCH_N}),
				8'({~v[5], ~v[3], v[2], ~v[1], ~v[0]}));
			rd(5'h1a, d);
			chk("cmd_rb", d, v & 8'h3f);
		end
		wr(5'h1a, 8'h24);
		wr(5'h19, 8'hff);
		rd(5'h03, d);
		chk("unmapped", d, 8'h00);
		for (int i = 0; i < 10; i++) begin
			@(posedge CLOCK);
			v = 8'($random(seed));
			{HOLD_BUSY, HOLD_ACK_N, MEDIA, ONLINE, FAULT_N} <= v[4:0];
			repeat (6) @(posedge CLOCK);
			rd(5'h19, d);
			chk("status", d, stat_exp());
		end
		{HOLD_BUSY, HOLD_ACK_N} <= 2'b01;
		EXT_EN <= 1'b1;
		EXT_VAL <= 8'($random(seed));
		repeat (6) @(posedge CLOCK);
		rd(5'h18, d);
		chk("data_in", d, EXT_VAL);
		EXT_EN <= 1'b0;
		u_pr.got.delete();
		wr(5'h1a, 8'h04);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			wr(5'h18, v);
			exp_q.push_back(v);
			repeat (3) @(posedge CLOCK);
			chk("dout", DOUT, v);
			rd(5'h18, d);
			chk("data_rb", d, v);
			strobe();
		end
		n = 0;
		@(negedge CLOCK);
		while (WR_READY === 1'b1 && n < 20) begin
			v = 8'($random(seed));
			wr(5'h18, v);
			exp_q.push_back(v);
			n++;
			@(negedge CLOCK);
		end
		chk("full", 8'(WR_READY), 8'h00);
		chk("accepted", 8'(n), 8'(printer_port_pkg::QUEUE_DEPTH + 1));
		wr(5'h18, ~v);
		rd(5'h18, d);
		chk("refused_rb", d, v);
		repeat (n) strobe();
		chk("count", 8'(u_pr.got.size()), 8'(exp_q.size()));
		foreach (exp_q[i]) begin
			chk("printed", u_pr.got[i], exp_q[i]);
		end
		// Reset again in mid-run with the pins driven
		wr(5'h1a, 8'h0e);
		@(posedge CLOCK);
		RST_N <= 1'b0;
		repeat (2) @(posedge CLOCK);
		RST_N <= 1'b1;
		@(negedge CLOCK);
		chk("pins_rst", 8'({OE, CH_N, INIT_N, LF_N, LATCH_N}), 8'h0f);
		chk("ready_rst", 8'(WR_READY), 8'h01);
		rd(5'h1a, d);
		chk("cmd_rst", d, 8'h24);
		end_sim();
	end
endmodule
